/* cmgc_pkg.sv */
// constants, field layouts and state carriers for the counter core
`default_nettype none
package cmgc_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] OFF_CTRL = 8'h00;   // control word
   localparam logic [7:0] OFF_CFG = 8'h04;    // mode configuration
   localparam logic [7:0] OFF_LOAD = 8'h08;   // load value
   localparam logic [7:0] OFF_END = 8'h0C;    // end value
   localparam logic [7:0] OFF_CMP = 8'h10;    // compare value
   localparam logic [7:0] OFF_COUNT = 8'h14;  // live counter value
   localparam logic [7:0] OFF_LATCH = 8'h18;  // latched value
   localparam logic [7:0] OFF_STATUS = 8'h1C; // status flags
   // control word bit positions
   localparam int CTRL_OPEN_BIT = 0;    // soft_gate_open_bit
   localparam int CTRL_CLOSE_BIT = 1;   // soft_gate_close_bit
   localparam int CTRL_CLR_BIT = 2;     // compare sticky clear
   localparam int CTRL_OUT_EN_BIT = 3;  // output_control_enable_flag
   localparam int CTRL_W = 4;           // control word width
   // run modes, main directions, output behaviours
   localparam logic [1:0] RUN_ONCE = 2'h0;
   localparam logic [1:0] RUN_PERIODIC = 2'h1;
   localparam logic [1:0] DIR_NONE = 2'h0;
   localparam logic [1:0] DIR_FWD = 2'h1;
   localparam logic [1:0] DIR_BWD = 2'h2;
   localparam logic [1:0] OUT_NEVER = 2'h0;
   localparam logic [1:0] OUT_GE = 2'h1;
   localparam logic [1:0] OUT_LE = 2'h2;
   localparam logic [1:0] OUT_PULSE = 2'h3;
   // fixed full-range limits
   localparam logic [31:0] CNT_MAX = 32'h7FFFFFFF;
   localparam logic [31:0] CNT_MIN = 32'h80000000;
   localparam logic [31:0] ONE = 32'h00000001;
   localparam logic [7:0] HYST_OFF_MAX = 8'h01;  // 0 and 1 disable
   // pulse step timing
   localparam int PULSE_STEP_NS = 2048000;  // 2.048 ms per step
   localparam int CLK_PERIOD_NS = 40;       // 25 MHz pclk
   localparam int PULSE_STEP_CYC = PULSE_STEP_NS / CLK_PERIOD_NS;
   // configuration word layout, low 24 bits of the cfg register
   typedef struct packed {
      logic [7:0] pulse_steps;  // pulse duration in steps
      logic [7:0] hyst;         // hysteresis width
      logic [1:0] out_mode;     // output_behaviour_param
      logic abort;              // 1 abort, 0 interrupt on reopen
      logic hw_en;              // hardware gate considered
      logic [1:0] dir;          // main counting direction
      logic [1:0] run_mode;     // single-run or periodic
   } cmgc_cfg_t;
   localparam cmgc_cfg_t CFG_RESET = 24'h000000;
   localparam int CFG_W = 24;
   // status register bit positions
   localparam int ST_IGATE = 0;
   localparam int ST_SWGATE = 1;
   localparam int ST_HWGATE = 2;
   localparam int ST_OUT = 3;     // output_state_flag
   localparam int ST_STICKY = 4;  // compare_sticky_flag
   localparam int ST_AUTO = 5;    // auto stop pending
   localparam int ST_HYST = 6;    // hysteresis active
   // whole state of the counter core
   typedef struct packed {
      logic [2:0] up_s;     // up pulse synchroniser and history
      logic [2:0] dn_s;     // down pulse synchroniser and history
      logic [2:0] gate_s;   // gate pin synchroniser and history
      logic [2:0] latch_s;  // latch pin synchroniser and history
      cmgc_cfg_t cfg;
      logic [CTRL_W-1:0] ctrl;
      logic [31:0] load;
      logic [31:0] endv;
      logic [31:0] cmp;
      logic [31:0] cnt;
      logic [31:0] latch;
      logic software_count_gate;      // software_count_gate
      logic auto_stop;    // gate closed by single-run limit
      logic hw_seen;      // hw rising seen during auto stop
      logic igate_q;      // internal gate last cycle
      logic moved;        // count stepped last cycle
      logic last_up;      // direction of that step
      logic prev_cond;    // level condition last cycle
      logic hyst_on;
      logic hyst_dir;     // stored direction, 1 upward
      logic [7:0] hyst_w; // width in force
      logic pulse_on;
      logic [7:0] ticks;  // elapsed pulse steps
      logic [31:0] div;   // step divider
      logic out_flag;     // output_state_flag
      logic sticky;       // compare_sticky_flag
      logic limit_evt;    // interrupt request pulse
      logic dout;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } cmgc_state_t;
endpackage : cmgc_pkg
`default_nettype wire

/* cmgc_core.sv */
// signed 32-bit counter with gates, latch, compare output and apb slave
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module cmgc_core #(
   parameter int PULSE_STEP_CYC = cmgc_pkg::PULSE_STEP_CYC  // pclk per step
) (
   input wire logic pclk,            // bus and core clock
   input wire logic presetn,         // async reset, low active
   input wire logic psel,            // apb select
   input wire logic penable,         // apb access phase
   input wire logic pwrite,          // apb direction
   input wire logic [7:0] paddr,     // apb byte address
   input wire logic [31:0] pwdata,   // apb write data
   output logic [31:0] prdata,       // apb read data
   output logic pready,              // apb ready
   output logic pslverr,             // apb error on unmapped
   input wire logic enc_up_pin,      // encoder up count pulse
   input wire logic enc_dn_pin,      // encoder down count pulse
   input wire logic gate_pin,        // hardware gate input
   input wire logic latch_pin,       // latch input
   output logic dout,                // digital compare output
   output logic limit_event          // end or limit interrupt pulse
);
   cmgc_pkg::cmgc_state_t r;     // registered state
   cmgc_pkg::cmgc_state_t n;     // next state
   logic up_e;                   // qualified up edge
   logic dn_e;                   // qualified down edge
   logic hw_lvl;                 // synchronised gate level
   logic hw_rise;                // gate rising edge
   logic latch_rise;             // latch rising edge
   logic commit;                 // apb transfer completing
   logic wr;                     // completing write
   logic open_e;                 // software gate open edge
   logic close_e;                // software gate close edge
   logic clr_e;                  // sticky clear request
   logic igate;                  // internal gate
   logic step;                   // one count step this cycle
   logic hit;                    // limit or end reached on step
   logic reload_reopen;          // abort reload on gate reopen
   logic release_auto;           // auto stop released
   logic cond;                   // level compare condition
   logic reach;                  // compare condition reached
   logic trigger;                // compare event outside hysteresis
   logic contrary;               // contrary exit of band
   logic signed [32:0] diff;     // count minus compare
   logic signed [32:0] wband;    // band half width
   logic in_band;                // inside hysteresis band
   logic tick;                   // pulse step elapsed

   // known register offsets
   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == cmgc_pkg::OFF_CTRL) || (a == cmgc_pkg::OFF_CFG) ||
                 (a == cmgc_pkg::OFF_LOAD) || (a == cmgc_pkg::OFF_END) ||
                 (a == cmgc_pkg::OFF_CMP) || (a == cmgc_pkg::OFF_COUNT) ||
                 (a == cmgc_pkg::OFF_LATCH) || (a == cmgc_pkg::OFF_STATUS);
   endfunction

   // read multiplexer, unmapped reads zero
   function automatic logic [31:0] rd_word(input logic [7:0] a,
                                           input cmgc_pkg::cmgc_state_t s);
      logic [31:0] st;
      st = 32'h00000000;
      st[cmgc_pkg::ST_IGATE] = s.software_count_gate & ~s.auto_stop &
                               (~s.cfg.hw_en | s.gate_s[1]);
      st[cmgc_pkg::ST_SWGATE] = s.software_count_gate;
      st[cmgc_pkg::ST_HWGATE] = s.gate_s[1];
      st[cmgc_pkg::ST_OUT] = s.out_flag;
      st[cmgc_pkg::ST_STICKY] = s.sticky;
      st[cmgc_pkg::ST_AUTO] = s.auto_stop;
      st[cmgc_pkg::ST_HYST] = s.hyst_on;
      case (a)
         cmgc_pkg::OFF_CTRL: rd_word = {28'h0000000, s.ctrl};
         cmgc_pkg::OFF_CFG: rd_word = {8'h00, s.cfg};
         cmgc_pkg::OFF_LOAD: rd_word = s.load;
         cmgc_pkg::OFF_END: rd_word = s.endv;
         cmgc_pkg::OFF_CMP: rd_word = s.cmp;
         cmgc_pkg::OFF_COUNT: rd_word = s.cnt;
         cmgc_pkg::OFF_LATCH: rd_word = s.latch;
         cmgc_pkg::OFF_STATUS: rd_word = st;
         default: rd_word = 32'h00000000;
      endcase
   endfunction

   // next-state logic of the whole core
   always_comb begin
      n = r;
      // pin synchronisers, stage two and three feed the edge detect
      n.up_s = {r.up_s[1:0], enc_up_pin};
      n.dn_s = {r.dn_s[1:0], enc_dn_pin};
      n.gate_s = {r.gate_s[1:0], gate_pin};
      n.latch_s = {r.latch_s[1:0], latch_pin};
      hw_lvl = r.gate_s[1];
      hw_rise = r.gate_s[1] & ~r.gate_s[2];
      latch_rise = r.latch_s[1] & ~r.latch_s[2];

      // apb: one wait state, effect at the edge with pready high
      commit = psel & penable & r.pready;
      wr = commit & pwrite & addr_hit(paddr);
      n.pready = psel & penable & ~r.pready;
      n.pslverr = n.pready & ~addr_hit(paddr);
      n.prdata = (n.pready & ~pwrite) ? rd_word(paddr, r) : 32'h00000000;

      // control word edges
      open_e = 1'b0;
      close_e = 1'b0;
      clr_e = 1'b0;
      if (wr && paddr == cmgc_pkg::OFF_CTRL) begin
         open_e = pwdata[cmgc_pkg::CTRL_OPEN_BIT] &
                  ~r.ctrl[cmgc_pkg::CTRL_OPEN_BIT];
         close_e = pwdata[cmgc_pkg::CTRL_CLOSE_BIT] &
                   ~r.ctrl[cmgc_pkg::CTRL_CLOSE_BIT];
         clr_e = pwdata[cmgc_pkg::CTRL_CLR_BIT];
         n.ctrl = pwdata[cmgc_pkg::CTRL_W-1:0];
      end
      if (wr && paddr == cmgc_pkg::OFF_CFG) begin
         n.cfg = cmgc_pkg::cmgc_cfg_t'(pwdata[cmgc_pkg::CFG_W-1:0]);
      end
      if (wr && paddr == cmgc_pkg::OFF_LOAD) begin
         n.load = pwdata;
      end
      if (wr && paddr == cmgc_pkg::OFF_END) begin
         n.endv = pwdata;
      end
      if (wr && paddr == cmgc_pkg::OFF_CMP) begin
         n.cmp = pwdata;
      end

      // software gate, close wins in a write carrying both edges
      if (open_e) begin
         n.software_count_gate = 1'b1;
      end
      if (close_e) begin
         n.software_count_gate = 1'b0;
      end

      // internal gate is software and masked hardware gate, held closed by auto stop
      igate = r.software_count_gate & (~r.cfg.hw_en | hw_lvl) & ~r.auto_stop;
      n.igate_q = igate;

      // abort reload: sw edge without hw, hw edge with hw
      reload_reopen = r.cfg.abort &
                      ((~r.cfg.hw_en & open_e & ~r.software_count_gate) |
                       (r.cfg.hw_en & hw_rise & r.software_count_gate));

      // leaving auto stop needs a fresh gate edge
      if (r.auto_stop && hw_rise) begin
         n.hw_seen = 1'b1;
      end
      release_auto = r.auto_stop &
                     (r.cfg.hw_en ? ((hw_rise & r.software_count_gate) |
                                     (open_e & hw_lvl & r.hw_seen))
                                  : open_e);
      if (release_auto) begin
         n.auto_stop = 1'b0;
         n.hw_seen = 1'b0;
      end

      // one signed step per qualified pulse
      up_e = r.up_s[1] & ~r.up_s[2];
      dn_e = r.dn_s[1] & ~r.dn_s[2];
      step = igate & (up_e ^ dn_e);
      hit = 1'b0;
      case (r.cfg.dir)
         cmgc_pkg::DIR_NONE: begin
            hit = up_e ? (r.cnt == cmgc_pkg::CNT_MAX)
                       : (r.cnt == cmgc_pkg::CNT_MIN);
         end
         cmgc_pkg::DIR_FWD: begin
            // end minus one then reload on an up pulse
            hit = up_e & (r.cnt == r.endv - cmgc_pkg::ONE);
         end
         cmgc_pkg::DIR_BWD: begin
            // end plus one then reload on a down pulse
            hit = dn_e & (r.cnt == r.endv + cmgc_pkg::ONE);
         end
         default: hit = 1'b0;
      endcase
      n.moved = step;
      n.last_up = up_e;
      n.limit_evt = step & hit;
      if (reload_reopen ||
          (release_auto && r.cfg.abort)) begin
         // aborting restart begins at the load value
         n.cnt = r.load;
      end else if (step) begin
         if (hit && (r.cfg.dir != cmgc_pkg::DIR_NONE ||
                     r.cfg.run_mode == cmgc_pkg::RUN_PERIODIC)) begin
            n.cnt = r.load;
         end else begin
            // natural wrap gives the opposite limit
            n.cnt = up_e ? r.cnt + cmgc_pkg::ONE : r.cnt - cmgc_pkg::ONE;
         end
         if (hit && r.cfg.run_mode == cmgc_pkg::RUN_ONCE) begin
            n.auto_stop = 1'b1;
            n.hw_seen = 1'b0;
         end
      end

      // stop-to-run clears the latch, an edge copies the count
      if (igate && !r.igate_q) begin
         n.latch = 32'h00000000;
      end
      if (latch_rise && igate) begin
         n.latch = r.cnt;
      end

      case (r.cfg.out_mode)
         cmgc_pkg::OUT_GE: cond = $signed(r.cnt) >= $signed(r.cmp);
         cmgc_pkg::OUT_LE: cond = $signed(r.cnt) <= $signed(r.cmp);
         cmgc_pkg::OUT_PULSE: cond = (r.cnt == r.cmp);
         default: cond = 1'b0;
      endcase
      n.prev_cond = cond;
      // pulse arrival filtered by main direction
      if (r.cfg.out_mode == cmgc_pkg::OUT_PULSE) begin
         reach = r.moved & cond &
                 ((r.cfg.dir == cmgc_pkg::DIR_NONE) ||
                  (r.cfg.dir == cmgc_pkg::DIR_FWD && r.last_up) ||
                  (r.cfg.dir == cmgc_pkg::DIR_BWD && !r.last_up));
      end else begin
         reach = cond & ~r.prev_cond;
      end

      // band around the compare value, 33-bit to avoid overflow
      diff = $signed({r.cnt[31], r.cnt}) - $signed({r.cmp[31], r.cmp});
      wband = $signed({25'h0, r.hyst_w});
      in_band = (diff <= wband) && (diff >= -wband);
      trigger = reach & ~r.hyst_on;
      contrary = 1'b0;
      if (trigger && r.cfg.hyst > cmgc_pkg::HYST_OFF_MAX) begin
         // width and direction taken at the event
         n.hyst_on = 1'b1;
         n.hyst_dir = r.last_up;
         n.hyst_w = r.cfg.hyst;
      end
      if (r.hyst_on && !in_band) begin
         // only an exit against the stored direction pulses
         n.hyst_on = 1'b0;
         contrary = (diff > 0) != r.hyst_dir;
      end

      // output state per behaviour
      tick = 1'b0;
      case (r.cfg.out_mode)
         cmgc_pkg::OUT_GE, cmgc_pkg::OUT_LE: begin
            // follow the level, frozen inside an active band
            n.pulse_on = 1'b0;
            if (!r.hyst_on) begin
               n.out_flag = cond;
            end
         end
         cmgc_pkg::OUT_PULSE: begin
            if (r.pulse_on) begin
               // no retrigger while the pulse runs
               if (r.cfg.pulse_steps == 8'h00) begin
                  // zero duration ends with the condition
                  n.pulse_on = cond;
               end else begin
                  tick = (r.div == 32'(PULSE_STEP_CYC - 1));
                  n.div = tick ? 32'h00000000 : r.div + cmgc_pkg::ONE;
                  if (tick) begin
                     n.ticks = r.ticks + 8'h01;
                     if (r.ticks + 8'h01 >= r.cfg.pulse_steps) begin
                        n.pulse_on = 1'b0;
                     end
                  end
               end
            end else if (trigger || contrary) begin
               // timing starts with the output assertion
               n.pulse_on = 1'b1;
               n.ticks = 8'h00;
               n.div = 32'h00000000;
            end
            n.out_flag = n.pulse_on;
         end
         default: begin
            n.pulse_on = 1'b0;
            n.out_flag = 1'b0;
         end
      endcase

      // sticky flag, a new set beats the clear
      if (clr_e) begin
         n.sticky = 1'b0;
      end
      if (n.out_flag && !r.out_flag) begin
         n.sticky = 1'b1;
      end
      // pin driven only with the output enable bit
      n.dout = n.out_flag & n.ctrl[cmgc_pkg::CTRL_OUT_EN_BIT];
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.cfg <= cmgc_pkg::CFG_RESET;
      end else begin
         r <= n;
      end
   end

   // outputs straight from state flops
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign dout = r.dout;
   assign limit_event = r.limit_evt;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // apb answer one cycle into the access phase
   a_apb_wait_state: assert property (
      (psel && penable && !pready) |=> pready)
      else $error("pready late");
   a_apb_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_count_gated: assert property (
      (!igate && !reload_reopen && !release_auto) |=> $stable(r.cnt))
      else $error("count moved with gate closed");
   a_fwd_end_reload: assert property (
      (step && up_e && r.cfg.dir == cmgc_pkg::DIR_FWD &&
       r.cnt == r.endv - cmgc_pkg::ONE && !reload_reopen)
      |=> (r.cnt == $past(r.load)) &&
          (r.auto_stop == ($past(r.cfg.run_mode) == cmgc_pkg::RUN_ONCE)))
      else $error("forward end reload wrong");
   a_once_wrap_stop: assert property (
      (step && hit && r.cfg.dir == cmgc_pkg::DIR_NONE &&
       r.cfg.run_mode == cmgc_pkg::RUN_ONCE && !reload_reopen)
      |=> r.auto_stop && limit_event &&
          (r.cnt == ($past(up_e) ? cmgc_pkg::CNT_MIN : cmgc_pkg::CNT_MAX)))
      else $error("single-run wrap wrong");
   a_periodic_reload: assert property (
      (step && hit && r.cfg.dir == cmgc_pkg::DIR_NONE &&
       r.cfg.run_mode == cmgc_pkg::RUN_PERIODIC && !reload_reopen)
      |=> (r.cnt == $past(r.load)) && !r.auto_stop)
      else $error("periodic reload wrong");
   a_latch_capture: assert property (
      (latch_rise && igate) |=> r.latch == $past(r.cnt))
      else $error("latch missed");
   a_ge_level: assert property (
      (r.cfg.out_mode == cmgc_pkg::OUT_GE && !r.hyst_on)
      |=> r.out_flag == ($signed($past(r.cnt)) >= $signed($past(r.cmp))))
      else $error("ge output wrong");
   a_sticky_hold: assert property (
      (r.sticky && !clr_e) |=> r.sticky)
      else $error("sticky flag dropped");
   a_dout_enable: assert property (
      dout |-> r.out_flag && r.ctrl[cmgc_pkg::CTRL_OUT_EN_BIT])
      else $error("output without enable");

   c_auto_stop: cover property ($rose(r.auto_stop));
   c_fwd_reload: cover property (
      limit_event && r.cfg.dir == cmgc_pkg::DIR_FWD);
   c_pulse_done: cover property ($fell(r.pulse_on));
   c_contrary_exit: cover property (contrary);
endmodule : cmgc_core
`default_nettype wire

/* cmgc_pins_model.sv */
// pin-side model: encoder pulses, gate level and latch strobe
`timescale 1ns/100ps
`default_nettype none
module cmgc_pins_model (
   input wire logic pclk, // core clock
   output logic enc_up_pin, // up count pulse
   output logic enc_dn_pin, // down count pulse
   output logic gate_pin, // hardware gate level
   output logic latch_pin // latch strobe
);
   // pins idle low, gate closed
   initial begin
      {enc_up_pin, enc_dn_pin, gate_pin, latch_pin} = 4'h0;
   end
   // clean 0-1 edges
   // one pulse: high two cycles, then low until the core has seen it
   task automatic pulse(input int which);
      @(posedge pclk);
      case (which)
         0: enc_up_pin <= 1'b1;
         1: enc_dn_pin <= 1'b1;
         default: latch_pin <= 1'b1;
      endcase
      repeat (2) @(posedge pclk);
      {enc_up_pin, enc_dn_pin, latch_pin} <= 3'h0;
      repeat (5) @(posedge pclk);
   endtask
   task automatic level(input logic v);
      @(posedge pclk);
      gate_pin <= v;
      repeat (6) @(posedge pclk);
   endtask
endmodule // cmgc_pins_model
`default_nettype wire

/* counter_modes_gate_compare_test.sv */
// self-checking bench for the counter core
`timescale 1ns/100ps
`default_nettype none
module counter_modes_gate_compare_test;
   logic pclk, presetn; // clock and low-active reset
   logic psel, penable, pwrite, pready, pslverr, last_err; // apb control
   logic [7:0] paddr; // apb byte address
   logic [31:0] pwdata, prdata, rd; // apb data, last read word
   logic up, dn, gate, latch, dout, limit_event; // pins and outputs
   int fail_count = 0, n_compared = 0, n_limit = 0, cycles = 0;
   cmgc_core #(.PULSE_STEP_CYC(8)) i_cmgc_core (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .enc_up_pin(up), .enc_dn_pin(dn),
      .gate_pin(gate), .latch_pin(latch), .dout(dout),
      .limit_event(limit_event));
   cmgc_pins_model i_cmgc_pins_model (.pclk(pclk), .enc_up_pin(up),
      .enc_dn_pin(dn), .gate_pin(gate), .latch_pin(latch));
   // 25 mhz clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // limit pulse tally and hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (limit_event === 1'b1) n_limit <= n_limit + 1;
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      last_err = pslverr;
      {psel, penable} <= 2'h0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
         input string what);
      xfer(1'b0, a, 32'h0);
      chk(what, e, rd);
   endtask
   // control word: drop gate bits first so the next write is an edge
   task automatic sw(input logic [31:0] v);
      wr(cmgc_pkg::OFF_CTRL, v & 32'h8);
      wr(cmgc_pkg::OFF_CTRL, v);
   endtask
   task automatic step(input int w, n);
      repeat (n) i_cmgc_pins_model.pulse(w);
   endtask
   // main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = 43'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(cmgc_pkg::OFF_COUNT, 32'h0, "count");
      rdc(cmgc_pkg::OFF_CFG, 32'h0, "cfg");
      rdc(8'h40, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, last_err});
      $display("test reset done");
      // single run forward, load 5, end 8, aborting
      wr(cmgc_pkg::OFF_CFG, 32'h24);
      wr(cmgc_pkg::OFF_LOAD, 32'h5);
      wr(cmgc_pkg::OFF_END, 32'h8);
      sw(32'h1);
      rdc(cmgc_pkg::OFF_COUNT, 32'h5, "count open");
      step(0, 2);
      rdc(cmgc_pkg::OFF_COUNT, 32'h7, "count end-1");
      step(0, 1);
      rdc(cmgc_pkg::OFF_COUNT, 32'h5, "count reload");
      chk("limit", 32'h1, n_limit);
      step(0, 1);
      rdc(cmgc_pkg::OFF_COUNT, 32'h5, "count stopped");
      $display("test single forward done");
      // periodic backward, load 3, end 1
      wr(cmgc_pkg::OFF_CFG, 32'h29);
      wr(cmgc_pkg::OFF_LOAD, 32'h3);
      wr(cmgc_pkg::OFF_END, 32'h1);
      sw(32'h2);
      sw(32'h1);
      step(1, 2);
      rdc(cmgc_pkg::OFF_COUNT, 32'h3, "count reload");
      step(1, 1);
      rdc(cmgc_pkg::OFF_COUNT, 32'h2, "count runs on");
      chk("limit", 32'h2, n_limit);
      $display("test periodic backward done");
      // compare greater-or-equal, cmp 4, sticky flag, latch
      wr(cmgc_pkg::OFF_CFG, 32'h61);
      wr(cmgc_pkg::OFF_CMP, 32'h4);
      wr(cmgc_pkg::OFF_LOAD, 32'h3);
      sw(32'hA);
      sw(32'h9);
      chk("dout below", 32'h0, {31'h0, dout});
      step(0, 1);
      chk("dout at", 32'h1, {31'h0, dout});
      step(2, 1);
      rdc(cmgc_pkg::OFF_LATCH, 32'h4, "latch");
      step(1, 1);
      chk("dout left", 32'h0, {31'h0, dout});
      rdc(cmgc_pkg::OFF_STATUS, 32'h13, "status sticky");
      wr(cmgc_pkg::OFF_CTRL, 32'hD);
      rdc(cmgc_pkg::OFF_STATUS, 32'h3, "status cleared");
      wr(cmgc_pkg::OFF_CTRL, 32'h1);
      step(0, 1);
      chk("dout masked", 32'h0, {31'h0, dout});
      rdc(cmgc_pkg::OFF_STATUS, 32'h1B, "status flag");
      wr(cmgc_pkg::OFF_CTRL, 32'h3);
      step(0, 1);
      rdc(cmgc_pkg::OFF_COUNT, 32'h4, "count closed");
      $display("test compare done");
      // hardware gate, aborting: hw rise reloads
      wr(cmgc_pkg::OFF_CFG, 32'h31);
      wr(cmgc_pkg::OFF_LOAD, 32'hA);
      sw(32'h1);
      step(0, 1);
      rdc(cmgc_pkg::OFF_COUNT, 32'h4, "count hw low");
      i_cmgc_pins_model.level(1'b1);
      rdc(cmgc_pkg::OFF_COUNT, 32'hA, "count hw rise");
      step(0, 1);
      i_cmgc_pins_model.level(1'b0);
      step(0, 1);
      rdc(cmgc_pkg::OFF_COUNT, 32'hB, "count hw gated");
      $display("test hardware gate done");
      // pulse mode, forward only, two steps, interrupting gate
      wr(cmgc_pkg::OFF_CFG, 32'h200C5);
      wr(cmgc_pkg::OFF_CMP, 32'hC);
      sw(32'h2);
      step(0, 1);
      sw(32'h9);
      rdc(cmgc_pkg::OFF_COUNT, 32'hB, "count resumed");
      rdc(cmgc_pkg::OFF_LATCH, 32'h0, "latch cleared");
      step(0, 1);
      chk("dout pulse", 32'h1, {31'h0, dout});
      step(0, 1);
      chk("dout held", 32'h1, {31'h0, dout});
      repeat (8) @(posedge pclk);
      chk("dout ended", 32'h0, {31'h0, dout});
      step(1, 1);
      chk("dout wrong way", 32'h0, {31'h0, dout});
      // less-or-equal level mode at the compare value
      wr(cmgc_pkg::OFF_CFG, 32'h85);
      repeat (2) @(posedge pclk);
      chk("dout le", 32'h1, {31'h0, dout});
      step(0, 1);
      chk("dout le left", 32'h0, {31'h0, dout});
      $display("test pulse and le done");
      // single run, no direction: wrap at the top, stop, restart
      wr(cmgc_pkg::OFF_CFG, 32'h20);
      wr(cmgc_pkg::OFF_LOAD, 32'h7FFFFFFF);
      sw(32'h2);
      sw(32'h1);
      step(0, 1);
      rdc(cmgc_pkg::OFF_COUNT, 32'h80000000, "count wrap");
      chk("limit", 32'h3, n_limit);
      step(0, 1);
      rdc(cmgc_pkg::OFF_COUNT, 32'h80000000, "count wrap stop");
      sw(32'h1);
      rdc(cmgc_pkg::OFF_COUNT, 32'h7FFFFFFF, "count restart");
      $display("test single wrap done");
      print_verdict();
   end
endmodule // counter_modes_gate_compare_test
`default_nettype wire
